// *** pkg/usb_rx_dma_irq_regs.vh ***
`ifndef USB_RX_DMA_IRQ_REGS_VH
`define USB_RX_DMA_IRQ_REGS_VH
// Register indices; byte address is four times the index
`define IDX_GLOBAL_CTRL 12'h004
`define IDX_PER_CH_AGG 12'h010
`define IDX_AUTO_IN 12'h014
`define IDX_SRC_STATUS 12'h020
`define IDX_SRC_FORCE 12'h024
`define IDX_SRC_CLEAR 12'h028
`define IDX_MASK_READ 12'h02c
`define IDX_MASK_SET 12'h030
`define IDX_MASK_CLEAR 12'h034
`define IDX_MASKED 12'h038
`define IDX_END_ACK 12'h03c
`define IDX_TX_END_ACK 12'h088
`define IDX_TX_MASKED 12'h090
`define IDX_TX_RAW 12'h094
`define IDX_TX_MASK_SET 12'h098
`define IDX_TX_MASK_CLEAR 12'h09c
`define IDX_RX_PORT_CTRL 12'h0c0
`define IDX_RX_MASKED 12'h0d0
`define IDX_RX_RAW 12'h0d4
`define IDX_RX_MASK_SET 12'h0d8
`define IDX_RX_MASK_CLEAR 12'h0dc
`define IDX_RX_END_ACK 12'h0e0
`define IDX_RX_BUF_CNT 12'h100
`define IDX_RX_HEAD 12'h108
`define IDX_RX_COMP 12'h110
`define IDX_RX_MAX_PKT 12'h118
`define IDX_TEST_MODE 12'h40f
// Field positions
`define BIT_GLOBAL_AGG 4
`define BIT_RX_PORT_EN 0
`define POS_TX_EP 0
`define POS_RX_EP 9
`define POS_CORE 16
`define BIT_TEST_NAK 0
`define BIT_TEST_J 1
`define BIT_TEST_K 2
// Values and reset values
`define AUTO_IN_EACH 2'h1
`define AUTO_IN_ALWAYS 2'h3
`define MIN_BUF_CNT 8'h03
`define RST_MAX_PKT 11'h040
`define RST_ZERO32 32'h00000000
`endif

// *** hw/usb_rx_dma_irq_testmode.v ***
// How it works
// - Transparent mode: every USB packet closes a DMA packet and flags the channel.
// - Start needs buffer count of at least 3; each consumed buffer decrements it.
// - Aggregated mode merges full-size packets; flag only when DMA packet finishes.
// - Aggregated packet ends on short packet; exact multiple ends on zero-length packet.
// - Aggregation on for all channels by global bit, or per channel bit.
// - Host mode: on start issue IN token, take packets, flag channel on DMA packet end.
// - Host aggregated, field 01: token after each packet, none after DMA packet end.
// - Field 11: tokens continue past DMA packet ends.
// - Endpoint, core and DMA channel sources combine into one interrupt.
// - Core bits: 8 supply, 7 vbus low, 6 session, 5 disc, 4 conn, 3..0.
// - Source shows unmasked status; clear writes clear, force writes set.
// - Mask set and clear by one-writes; mask and masked status readable.
// - Interrupt output holds until software writes the end-of-interrupt register.
// - Tx and Rx DMA have raw, mask set/clear, masked and end-ack registers.
// - Test mode 0x01 answers every valid IN token with NAK.
// - Test mode 0x02 drives continuous J.
// - Test mode 0x04 drives continuous K.
// - Rx channel flag holds until completion pointer write matches hardware value.
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "usb_rx_dma_irq_regs.vh"
module usb_rx_dma_irq_testmode #(
  parameter CHANNELS = 4,
  parameter LEN_W = 11
) (
  input wire sys_clk,
  input wire arst_n,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [31:0] reg_rdata,
  input wire host_mode,
  input wire [3:0] endpoint_dma_enable,
  input wire rx_pkt_valid,
  input wire [1:0] rx_pkt_chan,
  input wire [LEN_W-1:0] rx_pkt_len,
  input wire [31:0] rx_eop_desc,
  output wire [3:0] rx_chan_ready,
  output reg [3:0] in_token_req,
  output reg [3:0] rx_dma_done,
  input wire [4:0] tx_ep_event,
  input wire [4:1] rx_ep_event,
  input wire [8:0] core_event,
  input wire [3:0] tx_dma_event,
  output wire irq,
  output wire nak_all_in_test,
  output wire drive_j,
  output wire drive_k
);

  reg [31:0] global_control_reg;
  reg [3:0] per_channel_aggregate_reg;
  reg [7:0] auto_in_token_reg;
  reg [31:0] rx_port_control_reg;
  reg [31:0] src_reg;
  reg [31:0] mask_reg;
  reg [3:0] tx_raw_reg;
  reg [3:0] tx_mask_reg;
  reg [3:0] rx_mask_reg;
  reg [7:0] usb_test_mode_select_reg;
  reg core_irq_reg;
  reg tx_irq_reg;
  reg rx_irq_reg;
  reg core_rearm_reg;
  reg tx_rearm_reg;
  reg rx_rearm_reg;
  reg [31:0] rd_next;

  wire [3:0] rx_raw;
  wire [4*8-1:0] cnt_flat;
  wire [4*32-1:0] head_flat;
  wire [4*32-1:0] comp_flat;
  wire [4*LEN_W-1:0] maxpkt_flat;
  wire [3:0] token_next;
  wire [3:0] done_next;

  // Decoded write strobes
  wire wr_ctrl = reg_write && (reg_addr == `IDX_GLOBAL_CTRL);
  wire wr_agg = reg_write && (reg_addr == `IDX_PER_CH_AGG);
  wire wr_auto = reg_write && (reg_addr == `IDX_AUTO_IN);
  wire wr_port = reg_write && (reg_addr == `IDX_RX_PORT_CTRL);
  wire wr_force = reg_write && (reg_addr == `IDX_SRC_FORCE);
  wire wr_clear = reg_write && (reg_addr == `IDX_SRC_CLEAR);
  wire wr_mset = reg_write && (reg_addr == `IDX_MASK_SET);
  wire wr_mclr = reg_write && (reg_addr == `IDX_MASK_CLEAR);
  wire wr_eoi = reg_write && (reg_addr == `IDX_END_ACK);
  wire wr_tx_mset = reg_write && (reg_addr == `IDX_TX_MASK_SET);
  wire wr_tx_mclr = reg_write && (reg_addr == `IDX_TX_MASK_CLEAR);
  wire wr_tx_eoi = reg_write && (reg_addr == `IDX_TX_END_ACK);
  wire wr_rx_mset = reg_write && (reg_addr == `IDX_RX_MASK_SET);
  wire wr_rx_mclr = reg_write && (reg_addr == `IDX_RX_MASK_CLEAR);
  wire wr_rx_eoi = reg_write && (reg_addr == `IDX_RX_END_ACK);
  wire wr_test = reg_write && (reg_addr == `IDX_TEST_MODE);

  // Hardware source events in register layout
  wire [31:0] src_event = {7'h00, core_event, 3'h0, rx_ep_event, 4'h0, tx_ep_event};
  wire [31:0] masked = src_reg & mask_reg;
  wire [3:0] tx_masked = tx_raw_reg & tx_mask_reg;
  wire [3:0] rx_masked = rx_raw & rx_mask_reg;
  wire port_en = rx_port_control_reg[`BIT_RX_PORT_EN];
  wire global_agg = global_control_reg[`BIT_GLOBAL_AGG];

  // Per-channel receive DMA engine
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : ch_g
      reg [7:0] cnt_reg;
      reg [31:0] head_reg;
      reg [31:0] comp_reg;
      reg [LEN_W-1:0] maxpkt_reg;
      reg active_reg;
      reg raw_reg;
      // Channel number as a ranged constant, so its low bits can be selected
      localparam [31:0] ch_num = gi;
      wire [1:0] auto_f = auto_in_token_reg[2*gi+1:2*gi];
      wire agg = global_agg | per_channel_aggregate_reg[gi];
      wire ready = active_reg && (cnt_reg != 8'h00);
      wire hit = rx_pkt_valid && (rx_pkt_chan == ch_num[1:0]) && ready;
      wire short_pkt = rx_pkt_len < maxpkt_reg;
      wire pkt_end = hit && (!agg || short_pkt);
      wire wr_cnt = reg_write && (reg_addr == (`IDX_RX_BUF_CNT + ch_num[11:0]));
      wire wr_head = reg_write && (reg_addr == (`IDX_RX_HEAD + ch_num[11:0]));
      wire wr_comp = reg_write && (reg_addr == (`IDX_RX_COMP + ch_num[11:0]));
      wire wr_max = reg_write && (reg_addr == (`IDX_RX_MAX_PKT + ch_num[11:0]));
      // Start only with enables set and enough buffers queued
      wire start = wr_head && (reg_wdata != `RST_ZERO32) && port_en &&
                   endpoint_dma_enable[gi] && (cnt_reg >= `MIN_BUF_CNT);
      // Auto tokens are a host-side feature of aggregated mode only
      wire auto_tok = hit && agg && (((auto_f == `AUTO_IN_EACH) && !pkt_end) ||
                      (auto_f == `AUTO_IN_ALWAYS));
      assign token_next[gi] = host_mode && (start || auto_tok);
      assign done_next[gi] = pkt_end;
      assign rx_chan_ready[gi] = ready;
      assign rx_raw[gi] = raw_reg;
      assign cnt_flat[8*gi+7:8*gi] = cnt_reg;
      assign head_flat[32*gi+31:32*gi] = head_reg;
      assign comp_flat[32*gi+31:32*gi] = comp_reg;
      assign maxpkt_flat[LEN_W*gi+LEN_W-1:LEN_W*gi] = maxpkt_reg;

      // Software load of the count wins over a same-cycle decrement
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          cnt_reg <= 8'h00;
        end else if (wr_cnt) begin
          cnt_reg <= reg_wdata[7:0];
        end else if (hit) begin
          cnt_reg <= cnt_reg - 8'h01;
        end
      end

      // Head write starts; writing zero stops the channel
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          head_reg <= `RST_ZERO32;
          active_reg <= 1'b0;
          maxpkt_reg <= `RST_MAX_PKT;
        end else begin
          if (wr_head) begin
            head_reg <= reg_wdata;
            active_reg <= start;
          end
          if (wr_max) begin
            maxpkt_reg <= reg_wdata[LEN_W-1:0];
          end
        end
      end

      // Completion flag: a new completion beats a matching acknowledge
      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          comp_reg <= `RST_ZERO32;
          raw_reg <= 1'b0;
        end else if (pkt_end) begin
          comp_reg <= rx_eop_desc;
          raw_reg <= 1'b1;
        end else if (wr_comp && (reg_wdata == comp_reg)) begin
          raw_reg <= 1'b0;
        end
      end
    end
  endgenerate

  // Control registers written by software
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      global_control_reg <= `RST_ZERO32;
      per_channel_aggregate_reg <= 4'h0;
      auto_in_token_reg <= 8'h00;
      rx_port_control_reg <= `RST_ZERO32;
      usb_test_mode_select_reg <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        global_control_reg <= reg_wdata;
      end
      if (wr_agg) begin
        per_channel_aggregate_reg <= reg_wdata[3:0];
      end
      if (wr_auto) begin
        auto_in_token_reg <= reg_wdata[7:0];
      end
      if (wr_port) begin
        rx_port_control_reg <= reg_wdata;
      end
      if (wr_test) begin
        usb_test_mode_select_reg <= reg_wdata[7:0];
      end
    end
  end

  // Sticky sources; hardware and force set win over clear
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_reg <= `RST_ZERO32;
      tx_raw_reg <= 4'h0;
    end else begin
      src_reg <= (src_reg & ~(wr_clear ? reg_wdata : `RST_ZERO32)) | src_event |
                 (wr_force ? reg_wdata : `RST_ZERO32);
      tx_raw_reg <= tx_raw_reg | tx_dma_event;
    end
  end

  // Enable masks: one-writes set or clear individual bits
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_reg <= `RST_ZERO32;
      tx_mask_reg <= 4'h0;
      rx_mask_reg <= 4'h0;
    end else begin
      if (wr_mset) begin
        mask_reg <= mask_reg | reg_wdata;
      end else if (wr_mclr) begin
        mask_reg <= mask_reg & ~reg_wdata;
      end
      if (wr_tx_mset) begin
        tx_mask_reg <= tx_mask_reg | reg_wdata[3:0];
      end else if (wr_tx_mclr) begin
        tx_mask_reg <= tx_mask_reg & ~reg_wdata[3:0];
      end
      if (wr_rx_mset) begin
        rx_mask_reg <= rx_mask_reg | reg_wdata[3:0];
      end else if (wr_rx_mclr) begin
        rx_mask_reg <= rx_mask_reg & ~reg_wdata[3:0];
      end
    end
  end

  // Interrupt latches: held until end-ack, re-armed the cycle after if still pending
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      core_irq_reg <= 1'b0;
      tx_irq_reg <= 1'b0;
      rx_irq_reg <= 1'b0;
      core_rearm_reg <= 1'b0;
      tx_rearm_reg <= 1'b0;
      rx_rearm_reg <= 1'b0;
    end else begin
      core_rearm_reg <= wr_eoi;
      tx_rearm_reg <= wr_tx_eoi;
      rx_rearm_reg <= wr_rx_eoi;
      core_irq_reg <= (|(src_event & mask_reg)) || (core_irq_reg && !wr_eoi) ||
                      (core_rearm_reg && (|masked));
      tx_irq_reg <= (|(tx_dma_event & tx_mask_reg)) || (tx_irq_reg && !wr_tx_eoi) ||
                    (tx_rearm_reg && (|tx_masked));
      rx_irq_reg <= (|(done_next & rx_mask_reg)) || (rx_irq_reg && !wr_rx_eoi) ||
                    (rx_rearm_reg && (|rx_masked));
    end
  end

  assign irq = core_irq_reg | tx_irq_reg | rx_irq_reg;

  // Registered link-side pulses
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      in_token_req <= 4'h0;
      rx_dma_done <= 4'h0;
    end else begin
      in_token_req <= token_next;
      rx_dma_done <= done_next;
    end
  end

  // Test mode line controls; J and K are exclusive, J takes priority
  assign nak_all_in_test = usb_test_mode_select_reg[`BIT_TEST_NAK];
  assign drive_j = usb_test_mode_select_reg[`BIT_TEST_J];
  assign drive_k = usb_test_mode_select_reg[`BIT_TEST_K] && !drive_j;

  // Read mux; unmapped indices read zero, but 0x104-0x107, 0x10c-0x10f, 0x114-0x117 and 0x11c-0x11f alias channels 0-3
  always @* begin
    rd_next = `RST_ZERO32;
    case (reg_addr)
      `IDX_GLOBAL_CTRL: rd_next = global_control_reg;
      `IDX_PER_CH_AGG: rd_next = {28'h0000000, per_channel_aggregate_reg};
      `IDX_AUTO_IN: rd_next = {24'h000000, auto_in_token_reg};
      `IDX_SRC_STATUS: rd_next = src_reg;
      `IDX_MASK_READ: rd_next = mask_reg;
      `IDX_MASKED: rd_next = masked;
      `IDX_TX_RAW: rd_next = {28'h0000000, tx_raw_reg};
      `IDX_TX_MASKED: rd_next = {28'h0000000, tx_masked};
      `IDX_RX_PORT_CTRL: rd_next = rx_port_control_reg;
      `IDX_RX_RAW: rd_next = {28'h0000000, rx_raw};
      `IDX_RX_MASKED: rd_next = {28'h0000000, rx_masked};
      `IDX_TEST_MODE: rd_next = {24'h000000, usb_test_mode_select_reg};
      default: begin
        if (reg_addr[11:3] == `IDX_RX_BUF_CNT >> 3) begin
          rd_next = {24'h000000, cnt_flat[8*reg_addr[1:0] +: 8]};
        end else if (reg_addr[11:3] == `IDX_RX_HEAD >> 3) begin
          rd_next = head_flat[32*reg_addr[1:0] +: 32];
        end else if (reg_addr[11:3] == `IDX_RX_COMP >> 3) begin
          rd_next = comp_flat[32*reg_addr[1:0] +: 32];
        end else if (reg_addr[11:3] == `IDX_RX_MAX_PKT >> 3) begin
          rd_next = {{(32-LEN_W){1'b0}}, maxpkt_flat[LEN_W*reg_addr[1:0] +: LEN_W]};
        end
      end
    endcase
  end

  // Read data stand one cycle after the strobe, zero otherwise
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= `RST_ZERO32;
    end else begin
      reg_rdata <= reg_read ? rd_next : `RST_ZERO32;
    end
  end

endmodule

// *** sim/usb_rx_dma_irq_testmode_asserts.sv ***
`timescale 1ns/1ps
`include "usb_rx_dma_irq_regs.vh"
module usb_rx_dma_irq_testmode_asserts (
  input wire sys_clk,
  input wire arst_n,
  input wire [11:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_write,
  input wire host_mode,
  input wire rx_pkt_valid,
  input wire [1:0] rx_pkt_chan,
  input wire [3:0] in_token_req,
  input wire [3:0] rx_dma_done,
  input wire irq,
  input wire nak_all_in_test,
  input wire drive_j,
  input wire drive_k
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Decoded writes; any of the three acks may drop the line
  wire tm_wr = reg_write && reg_addr == `IDX_TEST_MODE;
  wire ack_wr = reg_write && (reg_addr == `IDX_END_ACK ||
    reg_addr == `IDX_TX_END_ACK || reg_addr == `IDX_RX_END_ACK);
  a_done_one_chan: assert property (rx_dma_done != 4'h0 |-> $past(rx_pkt_valid) &&
    rx_dma_done == (4'h1 << $past(rx_pkt_chan))) else $error("done without its packet");
  a_token_host_only: assert property (in_token_req != 4'h0 |-> $past(host_mode))
    else $error("token outside host mode");
  a_irq_fall_ack: assert property ($fell(irq) |-> $past(ack_wr))
    else $error("irq dropped without ack");
  a_nak_write: assert property (tm_wr |=> nak_all_in_test == $past(reg_wdata[0]))
    else $error("nak mode wrong");
  a_j_write: assert property (tm_wr |=> drive_j == $past(reg_wdata[1]))
    else $error("j mode wrong");
  a_k_write: assert property (tm_wr |=> drive_k ==
    ($past(reg_wdata[2]) && !$past(reg_wdata[1]))) else $error("k mode wrong");
  a_j_k_apart: assert property (!(drive_j && drive_k)) else $error("j and k together");
  a_test_mode_hold: assert property (!tm_wr |=>
    $stable({nak_all_in_test, drive_j, drive_k})) else $error("test mode moved");
  c_done: cover property (rx_dma_done != 4'h0);
  c_token: cover property (in_token_req != 4'h0);
  c_ack: cover property ($fell(irq));
endmodule
bind usb_rx_dma_irq_testmode usb_rx_dma_irq_testmode_asserts u_chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .host_mode(host_mode), .rx_pkt_valid(rx_pkt_valid), .rx_pkt_chan(rx_pkt_chan),
  .in_token_req(in_token_req), .rx_dma_done(rx_dma_done), .irq(irq),
  .nak_all_in_test(nak_all_in_test), .drive_j(drive_j), .drive_k(drive_k));

// *** sim/usb_far_side.sv ***
`timescale 1ns/1ps
module usb_far_side (
  input wire sys_clk,
  output reg rx_pkt_valid,
  output reg [1:0] rx_pkt_chan,
  output reg [10:0] rx_pkt_len,
  output reg [31:0] rx_eop_desc
);
  reg hold = 1'b0;
  initial begin
    rx_pkt_valid = 1'b0;
    rx_pkt_chan = 2'h0;
    rx_pkt_len = 11'h000;
    rx_eop_desc = 32'h0;
  end
  // Lines churn between packets so stale values never pass
  always @(posedge sys_clk) begin
    if (!hold) begin
      rx_pkt_chan <= ~rx_pkt_chan;
      rx_pkt_len <= ~rx_pkt_len;
      rx_eop_desc <= ~rx_eop_desc;
    end
  end
  // One whole packet; callers keep len within one 64-byte packet
  task send(input [1:0] ch, input [10:0] len, input [31:0] desc);
    begin
      #1 hold = 1'b1;
      @(posedge sys_clk);
      rx_pkt_valid <= 1'b1;
      rx_pkt_chan <= ch;
      rx_pkt_len <= len;
      rx_eop_desc <= desc;
      @(posedge sys_clk);
      rx_pkt_valid <= 1'b0;
      hold <= 1'b0;
    end
  endtask
endmodule

// *** sim/test_usb_rx_dma_irq_testmode.sv ***
`timescale 1ns/1ps
`include "usb_rx_dma_irq_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: %h vs %h", $time, g, e); end end
module test_usb_rx_dma_irq_testmode;
  reg sys_clk = 1'b0;
  reg arst_n = 1'b0;
  reg [11:0] reg_addr = 12'h000;
  reg [31:0] reg_wdata = 32'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg host_mode = 1'b0;
  reg [3:0] dma_en = 4'h0;
  reg [17:0] ev_bus = 18'h0;
  reg [3:0] tx_dma_ev = 4'h0;
  wire [31:0] reg_rdata;
  wire rx_pkt_valid;
  wire [1:0] rx_pkt_chan;
  wire [10:0] rx_pkt_len;
  wire [31:0] rx_eop_desc;
  wire [3:0] rx_chan_ready, in_token_req, rx_dma_done;
  wire irq, nak_all_in_test, drive_j, drive_k;
  integer n_errors = 0, compares = 0, cycles = 0, toks = 0, dones = 0, t0, d0, i;
  initial forever #50 sys_clk = ~sys_clk;
  usb_rx_dma_irq_testmode u_usb_rx_dma_irq_testmode (.sys_clk(sys_clk), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .host_mode(host_mode), .endpoint_dma_enable(dma_en),
    .rx_pkt_valid(rx_pkt_valid), .rx_pkt_chan(rx_pkt_chan), .rx_pkt_len(rx_pkt_len),
    .rx_eop_desc(rx_eop_desc), .rx_chan_ready(rx_chan_ready), .in_token_req(in_token_req),
    .rx_dma_done(rx_dma_done), .tx_ep_event(ev_bus[4:0]), .rx_ep_event(ev_bus[8:5]),
    .core_event(ev_bus[17:9]), .tx_dma_event(tx_dma_ev), .irq(irq),
    .nak_all_in_test(nak_all_in_test), .drive_j(drive_j), .drive_k(drive_k));
  usb_far_side u_usb_far_side (.sys_clk(sys_clk), .rx_pkt_valid(rx_pkt_valid),
    .rx_pkt_chan(rx_pkt_chan), .rx_pkt_len(rx_pkt_len), .rx_eop_desc(rx_eop_desc));
  // Pulse tallies; a hang ends as a failure
  always @(posedge sys_clk) begin
    toks <= toks + $countones(in_token_req);
    dones <= dones + $countones(rx_dma_done);
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  function [31:0] smap(input [17:0] v);
    smap = {7'h0, v[17:9], 3'h0, v[8:5], 4'h0, v[4:0]};
  endfunction
  task wr(input [11:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_write <= 1'b0;
    end
  endtask
  // Data stand only in the cycle after the strobe
  task rd(input [11:0] a, input [31:0] e);
    begin
      @(posedge sys_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_read <= 1'b0;
      #1 `CHK(reg_rdata, e)
    end
  endtask
  task ev(input [17:0] v);
    begin
      @(posedge sys_clk);
      ev_bus <= v;
      @(posedge sys_clk);
      ev_bus <= 18'h0;
    end
  endtask
  task settle;
    begin
      repeat (3) @(posedge sys_clk);
      #1;
    end
  endtask
  task tally_and_finish;
    begin
      if (n_errors == 0 && compares > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(`IDX_RX_MAX_PKT, 32'h40);
    rd(12'h3fe, 32'h0);
    `CHK(rx_chan_ready, 4'h0)
    wr(`IDX_MASK_SET, smap(18'h3ffff));
    rd(`IDX_MASK_READ, smap(18'h3ffff));
    for (i = 0; i < 18; i++) begin
      ev(18'h1 << i);
      rd(`IDX_SRC_STATUS, smap(18'h1 << i));
      rd(`IDX_MASKED, smap(18'h1 << i));
      wr(`IDX_END_ACK, 32'h0);
      settle;
      `CHK(irq, 1'b1)
      wr(`IDX_SRC_CLEAR, smap(18'h1 << i));
      wr(`IDX_END_ACK, 32'h0);
      settle;
      `CHK(irq, 1'b0)
    end
    wr(`IDX_MASK_CLEAR, 32'hffffffff);
    wr(`IDX_SRC_FORCE, 32'h00010000);
    rd(`IDX_SRC_STATUS, 32'h00010000);
    rd(`IDX_MASKED, 32'h0);
    `CHK(irq, 1'b0)
    wr(`IDX_TX_MASK_SET, 32'h4);
    @(posedge sys_clk) tx_dma_ev <= 4'h4;
    @(posedge sys_clk) tx_dma_ev <= 4'h0;
    rd(`IDX_TX_RAW, 32'h4);
    rd(`IDX_TX_MASKED, 32'h4);
    `CHK(irq, 1'b1)
    wr(`IDX_TX_MASK_CLEAR, 32'h4);
    rd(`IDX_TX_MASKED, 32'h0);
    wr(`IDX_TX_END_ACK, 32'h0);
    settle;
    `CHK(irq, 1'b0)
    // Transparent channel 1: a short count must not start it
    @(posedge sys_clk) host_mode <= 1'b1;
    dma_en <= 4'hf;
    wr(`IDX_RX_PORT_CTRL, 32'h1);
    wr(`IDX_RX_MASK_SET, 32'hf);
    wr(`IDX_GLOBAL_CTRL, 32'h0);
    wr(`IDX_AUTO_IN, 32'h0);
    wr(`IDX_RX_BUF_CNT + 12'h1, 32'h2);
    wr(`IDX_RX_HEAD + 12'h1, 32'h1000);
    settle;
    `CHK(rx_chan_ready, 4'h0)
    wr(`IDX_RX_BUF_CNT + 12'h1, 32'h3);
    t0 = toks;
    d0 = dones;
    wr(`IDX_RX_HEAD + 12'h1, 32'h1000);
    settle;
    `CHK(rx_chan_ready, 4'h2)
    u_usb_far_side.send(2'h1, 11'h040, 32'h1001);
    u_usb_far_side.send(2'h1, 11'h040, 32'h1002);
    u_usb_far_side.send(2'h1, 11'h020, 32'h1003);
    settle;
    `CHK(dones - d0, 3)
    `CHK(toks - t0, 1)
    `CHK(irq, 1'b1)
    rd(`IDX_RX_MASKED, 32'h2);
    rd(`IDX_RX_BUF_CNT + 12'h1, 32'h0);
    `CHK(rx_chan_ready, 4'h0)
    wr(`IDX_RX_COMP + 12'h1, 32'h1002);
    rd(`IDX_RX_RAW, 32'h2);
    wr(`IDX_RX_COMP + 12'h1, 32'h1003);
    rd(`IDX_RX_RAW, 32'h0);
    wr(`IDX_RX_END_ACK, 32'h0);
    settle;
    `CHK(irq, 1'b0)
    // Aggregated channel 2 by its own bit, tokens per packet
    wr(`IDX_PER_CH_AGG, 32'h4);
    wr(`IDX_AUTO_IN, 32'hd0);
    wr(`IDX_RX_BUF_CNT + 12'h2, 32'h5);
    t0 = toks;
    d0 = dones;
    wr(`IDX_RX_HEAD + 12'h2, 32'h2000);
    u_usb_far_side.send(2'h2, 11'h040, 32'h2001);
    u_usb_far_side.send(2'h2, 11'h040, 32'h2002);
    settle;
    `CHK(dones - d0, 0)
    u_usb_far_side.send(2'h2, 11'h010, 32'h2003);
    settle;
    `CHK(dones - d0, 1)
    `CHK(toks - t0, 3)
    u_usb_far_side.send(2'h2, 11'h040, 32'h2004);
    u_usb_far_side.send(2'h2, 11'h000, 32'h2005);
    settle;
    `CHK(dones - d0, 2)
    `CHK(toks - t0, 4)
    // Channel 3 aggregated by the global bit, tokens never stop
    wr(`IDX_GLOBAL_CTRL, 32'h10);
    wr(`IDX_RX_BUF_CNT + 12'h3, 32'h4);
    t0 = toks;
    d0 = dones;
    wr(`IDX_RX_HEAD + 12'h3, 32'h3000);
    u_usb_far_side.send(2'h3, 11'h040, 32'h3001);
    u_usb_far_side.send(2'h3, 11'h020, 32'h3002);
    u_usb_far_side.send(2'h3, 11'h040, 32'h3003);
    u_usb_far_side.send(2'h3, 11'h000, 32'h3004);
    settle;
    `CHK(dones - d0, 2)
    `CHK(toks - t0, 5)
    // Endpoint 0 status-phase event comes before any test mode write
    ev(18'h1);
    for (i = 0; i < 8; i++) begin
      wr(`IDX_TEST_MODE, i);
      settle;
      `CHK({nak_all_in_test, drive_j, drive_k}, {i[0], i[1], i[2] & ~i[1]})
      rd(`IDX_TEST_MODE, i);
    end
    tally_and_finish;
  end
endmodule
